//--- core/phy_strap_config_latch.sv
// Strap capture at chip reset release, shared pin turnaround, clock outputs.
// Assumes pins and chip reset are synchronous to sys_clk_in; APB master.
//
// What this block does
// - Chip reset active low; straps latch at release
// - Strap pins inputs in reset, outputs after except in power-down mode; ref clock pin also needs its enable
// - Three address straps give address 0..7
// - Address bits four and three always zero
// - Four-bit mode latched; 0001 normal, 0100 test
// - Reference clock pin level sets lamp style
// - High gives single lamp, low dual lamp
// - Reference clock pin drives 125 MHz after reset
// - Reference clock follows its enable strap level and the control ref bit
// - Top address strap captured before receive clock
// - Transmit clock driven out in MII mode
`default_nettype none
module phy_strap_config_latch
  import strap_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             chip_reset_n_in,
  input  wire logic [NPINS-1:0] strap_pin_in,
  output logic      [NPINS-1:0] strap_pin_out,
  output logic      [NPINS-1:0] strap_pin_oe_out,
  input  wire logic [NPINS-1:0] core_pin_data_in,
  output logic                  tx_clk_out,
  output logic      [4:0]       mgmt_addr_strap_out,
  output logic      [3:0]       op_mode_out,
  output logic                  lamp_style_strap_out,
  output logic                  ref_clock_out_enable_out,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out
);

  phase_t            phase_r;
  phase_t            phase_nxt;
  logic [4:0]        addr_r;
  logic [4:0]        addr_nxt;
  logic [3:0]        mode_r;
  logic [3:0]        mode_nxt;
  logic              lamp_r;
  logic              lamp_nxt;
  logic              ref_en_r;
  logic              ref_en_nxt;
  logic              ref_clk_r;
  logic [2:0]        mii_cnt_r;
  logic [2:0]        mii_cnt_nxt;
  logic              mii_clk_r;
  logic              mii_clk_nxt;
  logic [NPINS-1:0]  pin_out_r;
  logic [NPINS-1:0]  pin_out_nxt;
  logic [NPINS-1:0]  pin_oe_r;
  logic [NPINS-1:0]  pin_oe_nxt;
  logic              tx_clk_r;
  logic              tx_clk_nxt;
  logic [1:0]        ctrl_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;

  // Capture point: first edge with chip reset released
  wire go        = (phase_r == PH_RESET) && chip_reset_n_in;
  wire run_nxt   = (phase_nxt == PH_RUN);
  wire is_mii    = (mode_nxt == MODE_MII);
  wire is_nand   = (mode_nxt == MODE_NAND);
  wire is_pdown  = (mode_nxt == MODE_PDOWN);
  wire is_rsvd   = !is_mii && !is_nand && !is_pdown;
  wire drive_ok  = run_nxt && !is_pdown;
  wire ref_gate  = ctrl_r[CTRL_REF_BIT];
  wire tx_gate   = ctrl_r[CTRL_TX_BIT];

  // Chip reset re-entry wins over everything else
  assign phase_nxt = !chip_reset_n_in ? PH_RESET :
                     go               ? PH_RUN   : phase_r;

  // Pins are still inputs on the capture edge, so the MAC side is not yet driven
  assign addr_nxt   = go ? {ADDR_UPPER, strap_pin_in[PIN_ADDR2:PIN_ADDR0]} : addr_r;
  assign mode_nxt   = go ? strap_pin_in[PIN_MODE0+3:PIN_MODE0] : mode_r;
  assign lamp_nxt   = go ? strap_pin_in[PIN_LAMP] : lamp_r;
  assign ref_en_nxt = go ? strap_pin_in[PIN_CLKEN] : ref_en_r;

  // MII clock divider; free running so it needs no restart on mode change
  assign mii_cnt_nxt = (mii_cnt_r == MII_HALF_M1) ? 3'h0 : mii_cnt_r + 3'h1;
  assign mii_clk_nxt = (mii_cnt_r == MII_HALF_M1) ? !mii_clk_r : mii_clk_r;
  assign tx_clk_nxt  = run_nxt && is_mii && tx_gate && mii_clk_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      if (gi == PIN_LAMP)
      begin : g_ref
        // Half period of 125 MHz is one system cycle
        assign pin_out_nxt[gi] = !ref_clk_r;
        assign pin_oe_nxt[gi]  = drive_ok && ref_en_nxt && ref_gate;
      end
      else if (gi == PIN_ADDR2)
      begin : g_rxclk
        assign pin_out_nxt[gi] = mii_clk_nxt;
        assign pin_oe_nxt[gi]  = drive_ok;
      end
      else
      begin : g_data
        assign pin_out_nxt[gi] = core_pin_data_in[gi];
        assign pin_oe_nxt[gi]  = drive_ok;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_r  <= PH_RESET;
      addr_r   <= 5'h00;
      mode_r   <= 4'h0;
      lamp_r   <= 1'b0;
      ref_en_r <= 1'b0;
    end
    else
    begin
      phase_r  <= phase_nxt;
      addr_r   <= addr_nxt;
      mode_r   <= mode_nxt;
      lamp_r   <= lamp_nxt;
      ref_en_r <= ref_en_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ref_clk_r <= 1'b0;
      mii_cnt_r <= 3'h0;
      mii_clk_r <= 1'b0;
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      tx_clk_r  <= 1'b0;
    end
    else
    begin
      ref_clk_r <= !ref_clk_r;
      mii_cnt_r <= mii_cnt_nxt;
      mii_clk_r <= mii_clk_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      tx_clk_r  <= tx_clk_nxt;
    end
  end

  // APB slave: one wait state, answer registered
  wire        acc      = psel_in && penable_in && !pready_r;
  wire        done     = psel_in && penable_in && pready_r;
  wire        hit_st   = (paddr_in == REG_STATUS);
  wire        hit_ctrl = (paddr_in == REG_CTRL);
  wire        hit_pins = (paddr_in == REG_PINS);
  wire        hit      = hit_st || hit_ctrl || hit_pins;
  wire        ctrl_wr  = done && pwrite_in && hit_ctrl;
  wire [31:0] st_word  = {13'h0000, (phase_r == PH_RUN), (mode_r == MODE_PDOWN),
                          (mode_r != MODE_MII) && (mode_r != MODE_NAND) && (mode_r != MODE_PDOWN),
                          (mode_r == MODE_NAND), (mode_r == MODE_MII), ref_en_r, lamp_r,
                          mode_r, 3'h0, addr_r};
  wire [31:0] rd_mux   = hit_st   ? st_word :
                         hit_ctrl ? {30'h0, ctrl_r} :
                         hit_pins ? {23'h0, strap_pin_in} : 32'h0;

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_r    <= CTRL_RESET;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= acc;
      pslverr_r <= acc && !hit;
      prdata_r  <= (acc && !pwrite_in) ? rd_mux : 32'h0;
      if (ctrl_wr)
        ctrl_r <= pwdata_in[1:0];
    end
  end

  assign strap_pin_out            = pin_out_r;
  assign strap_pin_oe_out         = pin_oe_r;
  assign tx_clk_out               = tx_clk_r;
  assign mgmt_addr_strap_out      = addr_r;
  assign op_mode_out              = mode_r;
  assign lamp_style_strap_out     = lamp_r;
  assign ref_clock_out_enable_out = ref_en_r;
  assign prdata_out               = prdata_r;
  assign pready_out               = pready_r;
  assign pslverr_out              = pslverr_r;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_capture_on_release: assert property (
    go |=> (addr_r[2:0] == $past(strap_pin_in[2:0])) && (phase_r == PH_RUN))
    else $error("address not captured at reset release");

  chk_pins_input_reset: assert property (
    !chip_reset_n_in |=> (strap_pin_oe_out == '0))
    else $error("strap pin driven during chip reset");

  chk_pins_drive_after: assert property (
    go && (strap_pin_in[PIN_MODE0+3:PIN_MODE0] != MODE_PDOWN) ##1 chip_reset_n_in
      |=> strap_pin_oe_out[PIN_ADDR0] && strap_pin_oe_out[PIN_ADDR2])
    else $error("strap pins not driven after reset");

  chk_addr_upper_zero: assert property (
    mgmt_addr_strap_out[4:3] == ADDR_UPPER)
    else $error("address upper bits not zero");

  chk_mode_capture: assert property (
    go |=> (op_mode_out == $past(strap_pin_in[PIN_MODE0+3:PIN_MODE0])))
    else $error("mode not captured at reset release");

  chk_lamp_capture: assert property (
    go |=> (lamp_style_strap_out == $past(strap_pin_in[PIN_LAMP])))
    else $error("lamp style not captured");

  chk_ref_clock_rate: assert property (
    strap_pin_oe_out[PIN_LAMP] && $past(strap_pin_oe_out[PIN_LAMP])
      |-> (strap_pin_out[PIN_LAMP] != $past(strap_pin_out[PIN_LAMP])))
    else $error("reference clock not toggling each cycle");

  chk_ref_enable: assert property (
    strap_pin_oe_out[PIN_LAMP] |-> ref_clock_out_enable_out)
    else $error("reference clock driven with enable strap low");

  chk_rxclk_after_cap: assert property (
    go |-> !strap_pin_oe_out[PIN_ADDR2])
    else $error("receive clock pin driven at capture edge");

  chk_txclk_mii_only: assert property (
    $rose(tx_clk_out) |-> (op_mode_out == MODE_MII))
    else $error("transmit clock outside MII mode");

  chk_strap_hold: assert property (
    (phase_r == PH_RUN) && chip_reset_n_in
      |=> $stable(mgmt_addr_strap_out) && $stable(op_mode_out) && $stable(lamp_style_strap_out))
    else $error("latched strap changed without reset");

  chk_enable_hold: assert property (
    (phase_r == PH_RUN) && chip_reset_n_in
      |=> $stable(ref_clock_out_enable_out))
    else $error("reference clock enable changed without reset");

  chk_addr_capture: assert property (
    go |=> (mgmt_addr_strap_out == {ADDR_UPPER, $past(strap_pin_in[PIN_ADDR2:PIN_ADDR0])}))
    else $error("address word not captured at release");

  chk_enable_capture: assert property (
    go |=> (ref_clock_out_enable_out == $past(strap_pin_in[PIN_CLKEN])))
    else $error("reference clock enable not captured");

  // Ctrl may change on the same edge, so the gate as sampled decides
  chk_ref_drive_on: assert property (
    (phase_r == PH_RUN) && chip_reset_n_in && ref_en_r && ref_gate && (op_mode_out != MODE_PDOWN)
      |=> strap_pin_oe_out[PIN_LAMP])
    else $error("reference clock not driven with enable strap high");

  chk_pdown_no_drive: assert property (
    (op_mode_out == MODE_PDOWN) |-> (strap_pin_oe_out == '0))
    else $error("pin driven in power-down mode");

  chk_pins_stay_driven: assert property (
    (phase_r == PH_RUN) && chip_reset_n_in && (op_mode_out != MODE_PDOWN)
      |=> (strap_pin_oe_out[PIN_CLKEN:PIN_ADDR0] == 8'hff))
    else $error("shared pins released while running");

  chk_test_mode_drives: assert property (
    go && (is_nand || is_rsvd) |=> (strap_pin_oe_out[PIN_CLKEN:PIN_ADDR0] == 8'hff))
    else $error("pins not driven in test or reserved mode");

  chk_txclk_follows: assert property (
    (phase_r == PH_RUN) && chip_reset_n_in && (op_mode_out == MODE_MII) && tx_gate
      |=> (tx_clk_out == mii_clk_r))
    else $error("transmit clock not running in MII mode");

  chk_txclk_low_otherwise: assert property (
    (op_mode_out != MODE_MII) |-> !tx_clk_out)
    else $error("transmit clock active outside MII mode");

  // Divider runs free, so the half period holds across chip reset too
  chk_rxclk_half_period: assert property (
    $changed(strap_pin_out[PIN_ADDR2])
      |=> $stable(strap_pin_out[PIN_ADDR2])[*4] ##1 $changed(strap_pin_out[PIN_ADDR2]))
    else $error("receive clock half period wrong");

endmodule // phy_strap_config_latch
`default_nettype wire

//--- core/strap_pkg.sv
// Constants for the strap capture block: pin slots, mode codes, clocks, APB map.
// Assumes a 250 MHz system clock and 32-bit APB with word offsets.
`default_nettype none
package strap_pkg;
  localparam int unsigned SYS_CLK_HZ   = 250_000_000;
  localparam int unsigned REF_CLK_HZ   = 125_000_000;
  localparam int unsigned MII_CLK_HZ   = 25_000_000;
  localparam int unsigned MII_HALF_CYC = SYS_CLK_HZ / (2 * MII_CLK_HZ);
  localparam logic [2:0]  MII_HALF_M1  = 3'(MII_HALF_CYC - 1);
  localparam int unsigned NPINS     = 9;
  localparam int unsigned PIN_ADDR0 = 0;
  localparam int unsigned PIN_ADDR1 = 1;
  localparam int unsigned PIN_ADDR2 = 2;
  localparam int unsigned PIN_MODE0 = 3;
  localparam int unsigned PIN_CLKEN = 7;
  localparam int unsigned PIN_LAMP  = 8;
  localparam logic [3:0] MODE_MII   = 4'h1;
  localparam logic [3:0] MODE_NAND  = 4'h4;
  localparam logic [3:0] MODE_PDOWN = 4'h7;
  localparam logic [1:0] ADDR_UPPER = 2'h0;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_PINS   = 8'h08;
  localparam int unsigned ST_MODE_LSB  = 8;
  localparam int unsigned ST_LAMP_BIT  = 12;
  localparam int unsigned ST_CLKEN_BIT = 13;
  localparam int unsigned ST_MII_BIT   = 14;
  localparam int unsigned ST_NAND_BIT  = 15;
  localparam int unsigned ST_RSVD_BIT  = 16;
  localparam int unsigned ST_PDOWN_BIT = 17;
  localparam int unsigned ST_RUN_BIT   = 18;
  localparam int unsigned CTRL_REF_BIT = 0;
  localparam int unsigned CTRL_TX_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h3;
  typedef enum logic {PH_RESET, PH_RUN} phase_t;
endpackage
`default_nettype wire

//--- testbench/mac_pin_model.sv
// MAC side of the shared strap pins: pulls and pin resolution.
// Assumes per-pin device enables; pulls hold undriven pins.
`default_nettype none
module mac_pin_model
  import strap_pkg::*;
(
  input  wire logic [NPINS-1:0] pull_in,
  input  wire logic [NPINS-1:0] dev_out_in,
  input  wire logic [NPINS-1:0] dev_oe_in,
  output logic      [NPINS-1:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // MAC keeps off the pins, so pulls alone set undriven levels
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
      pin_out[i] = dev_oe_in[i] ? dev_out_in[i] : pull_in[i];
  end
endmodule // mac_pin_model
`default_nettype wire

//--- testbench/tb_top.sv
// Bench: strap pulls, APB traffic, reference model of latched state.
// Assumes mac_pin_model resolves the shared pins.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  logic             sys_clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             chip_reset_n_in = 1'b0;
  logic [NPINS-1:0] pull = '1;
  logic [NPINS-1:0] core_pin = '0;
  logic [NPINS-1:0] pin_lvl, pin_out, pin_oe;
  logic             tx_clk_out, lamp, clken, pready, pslverr;
  logic [4:0]       addr;
  logic [3:0]       mode;
  logic [31:0]      prdata;
  logic             psel_in = 1'b0;
  logic             penable_in = 1'b0;
  logic             pwrite_in = 1'b0;
  logic [7:0]       paddr_in = 8'h00;
  logic [31:0]      pwdata_in = 32'h0;
  logic [31:0]      seed = 32'h60;
  logic [3:0]       modes [8] = '{4'h1, 4'h4, 4'h7, 4'h0, 4'h2, 4'h3, 4'h1, 4'h9};
  int               num_errors = 0;
  int               checks = 0;

  always #2 sys_clk_in = ~sys_clk_in; // Ten times the 25 MHz crystal rate

  mac_pin_model mac (.pull_in(pull), .dev_out_in(pin_out), .dev_oe_in(pin_oe), .pin_out(pin_lvl));

  phy_strap_config_latch dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .chip_reset_n_in(chip_reset_n_in),
    .strap_pin_in(pin_lvl), .strap_pin_out(pin_out), .strap_pin_oe_out(pin_oe), .core_pin_data_in(core_pin),
    .tx_clk_out(tx_clk_out), .mgmt_addr_strap_out(addr), .op_mode_out(mode), .lamp_style_strap_out(lamp),
    .ref_clock_out_enable_out(clken), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [31:0] st_exp(input logic [8:0] p);
    logic [31:0] w;
    w = {29'h0, p[2:0]};
    w[ST_MODE_LSB +: 4] = p[6:3];
    w[ST_LAMP_BIT] = p[8];
    w[ST_CLKEN_BIT] = p[7];
    w[ST_MII_BIT] = (p[6:3] == 4'h1);
    w[ST_NAND_BIT] = (p[6:3] == 4'h4);
    w[ST_PDOWN_BIT] = (p[6:3] == 4'h7);
    w[ST_RSVD_BIT] = !(p[6:3] inside {4'h1, 4'h4, 4'h7});
    w[ST_RUN_BIT] = 1'b1;
    return w;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Extra idle edge at the end keeps two setups from landing in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    finish_test();
  end

  initial
  begin
    logic [31:0] rd;
    logic        er, a, pd, rf;
    logic [8:0]  p;
    int          ones, rx;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    apb(1'b0, REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h3);
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    for (int n = 0; n < 8; n++)
    begin
      seed = xs(seed);
      p = {seed[1:0], modes[n], seed[4:2]};
      pd = (p[6:3] == 4'h7);
      rf = p[7] && n != 5 && !pd;
      apb(1'b1, REG_CTRL, (n == 5) ? 32'h2 : (n == 6) ? 32'h1 : 32'h3, rd, er);
      chip_reset_n_in <= 1'b0;
      pull <= p;
      core_pin <= seed[20:12];
      repeat (3) @(posedge sys_clk_in);
      chk(pin_oe, 32'h0);
      apb(1'b0, REG_PINS, 32'h0, rd, er);
      chk(rd, {23'h0, p});
      chip_reset_n_in <= 1'b1;
      @(posedge sys_clk_in);
      // Pulls flip right after capture; latched state must ignore it
      pull <= ~p;
      repeat (2) @(posedge sys_clk_in);
      chk(addr[2:0], p[2:0]);
      chk(addr[4:3], 2'h0);
      chk(mode, p[6:3]);
      chk(lamp, p[8]);
      chk(clken, p[7]);
      chk(pin_oe, pd ? 9'h0 : {rf, 8'hff});
      if (!pd)
        chk(pin_out[1:0], core_pin[1:0]);
      apb(1'b0, REG_STATUS, 32'h0, rd, er);
      chk(rd, st_exp(p));
      a = pin_out[8];
      @(posedge sys_clk_in);
      if (rf)
        chk(pin_out[8] ^ a, 32'h1);
      ones = 0;
      rx = 0;
      repeat (4 * MII_HALF_CYC)
      begin
        @(posedge sys_clk_in);
        ones += tx_clk_out;
        rx += pin_out[2];
      end
      chk(ones, (p[6:3] == 4'h1 && n != 6) ? 2 * MII_HALF_CYC : 0);
      if (!pd)
        chk(rx, 2 * MII_HALF_CYC);
      chk({lamp, clken, mode, addr[2:0]}, p);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
